// file: inc/pdio_params.svh
// Constants for the programmable digital I/O port
`ifndef PDIO_PARAMS_SVH
`define PDIO_PARAMS_SVH
`define PDIO_NUM_PINS 8
`define PDIO_DIR_RESET 8'h00
`define PDIO_VALUE_RESET 8'h00
`define PDIO_IRQ_EN_RESET 8'h00
`define PDIO_FLAGS_RESET 8'h00
`define PDIO_SYNC_STAGES 3
`endif

// file: inc/pdio_pkg.sv
// Types shared by the programmable digital I/O port
package pdio_pkg;
  // Software access strobes with write data
  typedef struct packed {
    logic dir_wr;
    logic value_wr;
    logic irq_en_wr;
    logic flags_rd;
    logic [7:0] wdata;
  } pdio_sw_req_t;
  // Pin drive towards the pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pdio_pin_drive_t;
endpackage

// file: hdl/pdio_sync.sv
// Three-stage pin synchroniser with agreement filter
`include "pdio_params.svh"
module pdio_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_stable
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Only take a new level once stages two and three agree
  wire logic [WIDTH-1:0] agree;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign agree[g] = (s2_reg[g] == s3_reg[g]);
    end
  endgenerate
  // One process owns the whole output word, so no bit has two drivers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_stable <= '0;
    end else begin
      o_stable <= (s3_reg & agree) | (o_stable & ~agree);
    end
  end
endmodule // pdio_sync

// file: hdl/pdio_port.sv
// Programmable digital I/O port with change-of-state interrupt
// What this block does
// - Eight general pins, each independently input or output.
// - Each direction bit selects input or output for its pin.
// - Data reads return sampled levels on input pins and the output latch on output pins; writes set output levels.
// - Data writes change only pins configured as outputs.
// - After reset every pin is an input.
// - Pin interrupts only when input and enable bit set; software orders setup.
// - Any edge on an enabled input pin raises the peripheral request.
// - Each detected change sets that pin's change flag.
// - Reading the change flags returns them and clears them.
// - Active-low request held until all pending flags are acknowledged.
// - Flag read clears all bits at once, except those of pins changing in the read cycle, and re-arms interrupts.
`include "pdio_params.svh"
module pdio_port #(
  parameter int NUM_PINS = `PDIO_NUM_PINS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Software access
  input wire pdio_pkg::pdio_sw_req_t i_sw,
  // Register views
  output logic [NUM_PINS-1:0] o_pin_direction_reg,
  output logic [NUM_PINS-1:0] o_pin_value_reg,
  output logic [NUM_PINS-1:0] o_pin_irq_enable_reg,
  output logic [NUM_PINS-1:0] o_pin_change_flags,
  // Pins
  input wire logic [NUM_PINS-1:0] i_general_io_pins,
  output logic [NUM_PINS-1:0] o_general_io_pins,
  output logic [NUM_PINS-1:0] o_general_io_pins_oe,
  // Peripheral interrupt
  output logic o_peripheral_irq_line_n
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [NUM_PINS-1:0] dir_reg;
  logic [NUM_PINS-1:0] out_reg;
  logic [NUM_PINS-1:0] ien_reg;
  logic [NUM_PINS-1:0] flags_reg;
  logic [NUM_PINS-1:0] flags_next;
  logic [NUM_PINS-1:0] in_stable;
  logic [NUM_PINS-1:0] in_prev_reg;
  logic [NUM_PINS-1:0] change;
  logic [NUM_PINS-1:0] rd_view_reg;
  logic [NUM_PINS-1:0] flag_snap_reg;

  pdio_sync #(.WIDTH(NUM_PINS)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_general_io_pins),
    .o_stable(in_stable)
  );

  // ****************************************************************
  // Direction and output data
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dir_reg <= `PDIO_DIR_RESET;
    end else if (i_sw.dir_wr) begin
      dir_reg <= i_sw.wdata[NUM_PINS-1:0];
    end
  end

  // Input pins keep their old latch so turning them to outputs later is glitch free
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_reg <= `PDIO_VALUE_RESET;
    end else if (i_sw.value_wr) begin
      out_reg <= (out_reg & ~dir_reg) | (i_sw.wdata[NUM_PINS-1:0] & dir_reg);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ien_reg <= `PDIO_IRQ_EN_RESET;
    end else if (i_sw.irq_en_wr) begin
      ien_reg <= i_sw.wdata[NUM_PINS-1:0];
    end
  end

  // ****************************************************************
  // Change detection and flags
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      in_prev_reg <= '0;
    end else begin
      in_prev_reg <= in_stable;
    end
  end

  assign change = (in_stable ^ in_prev_reg) & ien_reg & ~dir_reg;

  // A change in the reading cycle survives the clear
  always_comb begin
    flags_next = flags_reg;
    if (i_sw.flags_rd) begin
      flags_next = '0;
    end
    flags_next = flags_next | change;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags_reg <= `PDIO_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Snapshot shown to software: the value at the read strobe is held
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flag_snap_reg <= '0;
    end else if (i_sw.flags_rd) begin
      flag_snap_reg <= flags_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_peripheral_irq_line_n <= 1'b1;
    end else begin
      o_peripheral_irq_line_n <= ~(|flags_next);
    end
  end

  // ****************************************************************
  // Read view and pin drive
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_view_reg <= '0;
    end else begin
      rd_view_reg <= (in_stable & ~dir_reg) | (out_reg & dir_reg);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_general_io_pins <= '0;
      o_general_io_pins_oe <= '0;
    end else begin
      o_general_io_pins <= out_reg;
      o_general_io_pins_oe <= dir_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin_direction_reg <= '0;
      o_pin_irq_enable_reg <= '0;
    end else begin
      o_pin_direction_reg <= dir_reg;
      o_pin_irq_enable_reg <= ien_reg;
    end
  end

  assign o_pin_value_reg = rd_view_reg;
  assign o_pin_change_flags = flag_snap_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_flag_read;
    i_sw.flags_rd && (flags_reg != '0) && (change == '0);
  endsequence

  a_flag_read_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_flag_read |=> (flags_reg == '0))
    else $error("Flags not cleared by read");
  a_flag_snapshot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_sw.flags_rd |=> (o_pin_change_flags == $past(flags_reg)))
    else $error("Flag read value wrong");
  a_change_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (change != '0) |=> ((flags_reg & $past(change)) == $past(change)))
    else $error("Change did not set flag");
  a_irq_low_pending: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (change != '0) |=> !o_peripheral_irq_line_n)
    else $error("Request not raised on change");
  a_irq_tracks_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (flags_reg != '0) && !i_sw.flags_rd |=> !o_peripheral_irq_line_n)
    else $error("Request released while flags pending");
  // New flags may only appear on pins that were enabled inputs
  a_no_irq_output: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ((flags_reg & ~$past(flags_reg)) & ($past(dir_reg) | ~$past(ien_reg))) == '0)
    else $error("Output or disabled pin raised a flag");
  a_write_masked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_sw.value_wr && !i_sw.dir_wr |=> ((out_reg ^ $past(out_reg)) & ~dir_reg) == '0)
    else $error("Write changed an input pin");
  a_dir_drives_oe: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_sw.dir_wr |=> ##1 (o_general_io_pins_oe == $past(i_sw.wdata[NUM_PINS-1:0], 2)))
    else $error("Direction not applied to pins");
  a_reset_inputs: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> (o_general_io_pins_oe == '0))
    else $error("Pins driven after reset");
endmodule // pdio_port

// file: bench/pdio_pad_model.sv
// Pad model: external circuits sharing the general pins
module pdio_pad_model (
  // Port drive
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  // Outside circuit levels
  input wire logic [7:0] i_ext,
  // Resolved pad levels
  output logic [7:0] o_pads
);
  timeunit 1ns;
  timeprecision 1ns;
  // The port wins where it drives, so an output pin never reads back outside noise
  assign o_pads = (i_oe & i_out) | (~i_oe & i_ext);
endmodule // pdio_pad_model

// file: bench/testbench.sv
// Self-checking bench for the programmable digital I/O port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pdio_pkg::pdio_sw_req_t sw = '0;
  logic [7:0] ext = 8'h00;
  logic [7:0] dir, val, ien, flags, pads, pout, poe;
  logic irq_n;
  int miscompares = 0;
  int total_checks = 0;

  // ***********************
  // Clock, design, pads
  // ***********************
  initial begin
    forever #5 clk = ~clk;
  end

  pdio_port i_pdio_port (
    .i_clk(clk), .i_sys_rst(rst), .i_sw(sw),
    .o_pin_direction_reg(dir), .o_pin_value_reg(val),
    .o_pin_irq_enable_reg(ien), .o_pin_change_flags(flags),
    .i_general_io_pins(pads), .o_general_io_pins(pout),
    .o_general_io_pins_oe(poe), .o_peripheral_irq_line_n(irq_n)
  );

  pdio_pad_model i_pdio_pad_model (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_pads(pads));

  // ***********************
  // Helpers
  // ***********************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Kind bits: dir_wr, value_wr, irq_en_wr, flags_rd
  task automatic strobe(input logic [3:0] kind, input logic [7:0] d);
    @(negedge clk);
    sw = {kind, d};
    @(negedge clk);
    sw = '0;
  endtask

  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ***********************
  // Scenarios
  // ***********************
  task automatic test_reset();
    check(dir, 8'h00);
    check(poe, 8'h00);
    check({7'h00, irq_n}, 8'h01);
  endtask

  task automatic test_outputs();
    strobe(4'h8, 8'h0F);
    strobe(4'h4, 8'hFF);
    repeat (2) @(negedge clk);
    check(dir, 8'h0F);
    check(poe, 8'h0F);
    // Input pins keep the old latch, so only the low nibble goes high
    check(pout, 8'h0F);
    ext = 8'hA0;
    repeat (8) @(negedge clk);
    check(val, 8'hAF);
  endtask

  task automatic test_changes();
    // Pin 0 is an output, so its enable bit must have no effect
    strobe(4'h2, 8'hE1);
    repeat (8) @(negedge clk);
    check(ien, 8'hE1);
    ext = 8'hB0;
    strobe(4'h4, 8'h0E);
    repeat (10) @(negedge clk);
    check({7'h00, irq_n}, 8'h01);
    check(pout, 8'h0E);
    ext = 8'h90;
    repeat (8) @(negedge clk);
    check({7'h00, irq_n}, 8'h00);
    strobe(4'h1, 8'h00);
    check(flags, 8'h20);
    check({7'h00, irq_n}, 8'h01);
    // Falling pin 7 and rising pin 5 together
    ext = 8'h30;
    repeat (12) @(negedge clk);
    check({7'h00, irq_n}, 8'h00);
    strobe(4'h1, 8'h00);
    check(flags, 8'hA0);
    strobe(4'h1, 8'h00);
    check(flags, 8'h00);
  endtask

  // Reset in mid-run, with outputs and enables set up
  task automatic test_reset_again();
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check(dir, 8'h00);
    check(poe, 8'h00);
    check(ien, 8'h00);
    check(pout, 8'h00);
    check({7'h00, irq_n}, 8'h01);
    strobe(4'h8, 8'hF0);
    repeat (8) @(negedge clk);
    check(poe, 8'hF0);
    check(val, 8'h00);
    check({7'h00, irq_n}, 8'h01);
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    test_reset();
    test_outputs();
    test_changes();
    test_reset_again();
    end_sim();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule // testbench
